// >>> hw/mcs_pkg.sv
// Constants shared by the module control and status registers.
// Assumes a 200 MHz module clock.
package mcs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 5;
  localparam int I2C_QTR_NS = 1250;
  localparam int I2C_QTR_CYC = I2C_QTR_NS / CLK_NS;
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [3:0] ADR_BOOT = 4'h0;
  localparam logic [3:0] ADR_STAT1 = 4'h1;
  localparam logic [3:0] ADR_STAT2 = 4'h2;
  localparam logic [3:0] ADR_VER_LOGIC = 4'h3;
  localparam logic [3:0] ADR_VER_FPGA = 4'h4;
  localparam logic [3:0] ADR_CAN_CTL = 4'h5;
  localparam logic [3:0] ADR_CAN_IRQ = 4'h6;
  localparam logic [3:0] ADR_I2C_CTL = 4'h7;
  localparam logic [3:0] ADR_I2C_STAT = 4'h8;
  localparam logic [3:0] ADR_I2C_ID = 4'h9;
  localparam logic [3:0] ADR_MOD_RST = 4'ha;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int BOOT_BIT = 0;
  localparam int COLL_LSB = 1;
  localparam int COLL_W = 3;
  localparam int GEO_LSB = 4;
  localparam int GEO_W = 8;
  localparam logic BOOT_RST = 1'b1;
  localparam int CAN_RST_BIT = 0;
  localparam int CAN_PROG_BIT = 1;
  localparam int IRQ_W = 4;
  localparam int I2C_DIR_BIT = 8;
  localparam int I2C_REG_LSB = 9;
  localparam int I2C_REG_W = 5;
  localparam int I2C_RST_BIT = 15;
  localparam logic [15:0] I2C_CTL_MASK = 16'hbfff;
  localparam int ID_W = 6;
  localparam int MOD_RST_BIT = 0;
endpackage : mcs_pkg

// >>> hw/mcs_pulse.sv
// Stretches a one-cycle request into a fixed-length strobe.
// Assumes trig is synchronous to clk.
`timescale 1ns/10ps
module mcs_pulse
  import mcs_pkg::*;
#(
  parameter int LEN = STROBE_CYC
) (
  input  logic clk,
  input  logic rstn,
  input  logic trig,
  output logic pulse
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       q;
  } mcs_pulse_t;
  mcs_pulse_t s, n;

  always_comb begin
    n = s;
    if (trig) begin
      n.cnt = 8'(LEN - 1);
      n.q = 1'b1;
    end else if (s.cnt != 8'h00) begin
      n.cnt = s.cnt - 8'h01;
    end else begin
      n.q = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s <= '0;
    else s <= n;
  end

  assign pulse = s.q;
endmodule : mcs_pulse

// >>> hw/mcs_i2c.sv
// Register access engine toward the timing receiver over I2C.
// Frame: address byte, register byte, data byte; open-drain pins.
`timescale 1ns/10ps
module mcs_i2c
  import mcs_pkg::*;
#(
  parameter int QTR = I2C_QTR_CYC
) (
  input  logic       clk,
  input  logic       rstn,
  input  logic       soft_rst,
  input  logic       launch,
  input  logic       dir,
  input  logic [4:0] regno,
  input  logic [7:0] wbyte,
  input  logic [5:0] base_id,
  input  logic       scl_in,
  input  logic       sda_in,
  output logic       scl_oe,
  output logic       sda_oe,
  output logic       busy,
  output logic       err,
  output logic [7:0] rbyte
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_START = 2'b01, ST_BITS = 2'b10, ST_STOP = 2'b11
  } mcs_st_t;
  typedef struct packed {
    mcs_st_t     st;
    logic [1:0]  q;
    logic [15:0] div;
    logic [3:0]  bit_i;
    logic [1:0]  byte_i;
    logic [7:0]  sh;
    logic        dir;
    logic [4:0]  regno;
    logic [7:0]  wbyte;
    logic        busy;
    logic        err;
    logic [7:0]  rbyte;
    logic        scl_oe;
    logic        sda_oe;
  } mcs_i2c_t;
  mcs_i2c_t s, n;
  logic adv;
  logic rx;

  always_comb begin
    n = s;
    // Released clock held low by the target stretches the quarter
    adv = (s.div == 16'(QTR - 1)) && (s.scl_oe || scl_in);
    rx = (s.byte_i == 2'd2) && !s.dir;
    n.div = (s.st == ST_IDLE || adv) ? 16'h0000 : s.div + 16'h0001;
    if (adv) n.q = s.q + 2'd1;
    unique case (s.st)
      ST_IDLE: begin
        if (launch) begin
          n.st = ST_START;
          n.busy = 1'b1;
          n.err = 1'b0;
          n.q = 2'd0;
          n.sh = {base_id, 1'b0, ~dir};
          n.dir = dir;
          n.regno = regno;
          n.wbyte = wbyte;
          n.byte_i = 2'd0;
          n.bit_i = 4'd0;
        end
      end
      ST_START: if (adv) begin
        if (s.q == 2'd0) n.sda_oe = 1'b1;
        if (s.q == 2'd1) n.scl_oe = 1'b1;
        if (s.q == 2'd3) begin
          n.st = ST_BITS;
          n.sda_oe = ~s.sh[7];
        end
      end
      ST_BITS: if (adv) begin
        if (s.q == 2'd0) n.scl_oe = 1'b0;
        if (s.q == 2'd2) begin
          n.scl_oe = 1'b1;
          if (s.bit_i == 4'd8) begin
            if (!rx && sda_in) n.err = 1'b1;
            if (rx) n.rbyte = s.sh;
          end else begin
            n.sh = {s.sh[6:0], sda_in};
          end
        end
        if (s.q == 2'd3) begin
          if (s.bit_i == 4'd8) begin
            if (s.err || s.byte_i == 2'd2) begin
              n.st = ST_STOP;
              n.sda_oe = 1'b1;
            end else begin
              n.byte_i = s.byte_i + 2'd1;
              n.bit_i = 4'd0;
              n.sh = (s.byte_i == 2'd0) ? {3'h0, s.regno} : (s.dir ? s.wbyte : 8'hff);
              n.sda_oe = (s.byte_i == 2'd1 && !s.dir) ? 1'b0
                       : (s.byte_i == 2'd0 ? 1'b1 : ~s.wbyte[7]);
            end
          end else begin
            n.bit_i = s.bit_i + 4'd1;
            // Acknowledge slot and received bits leave the line free
            n.sda_oe = (s.bit_i == 4'd7 || rx) ? 1'b0 : ~s.sh[7];
          end
        end
      end
      ST_STOP: if (adv) begin
        if (s.q == 2'd0) n.scl_oe = 1'b0;
        if (s.q == 2'd1) n.sda_oe = 1'b0;
        if (s.q == 2'd2) begin
          n.st = ST_IDLE;
          n.busy = 1'b0;
        end
      end
    endcase
    if (soft_rst) n = '0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s <= '0;
    else s <= n;
  end

  assign scl_oe = s.scl_oe;
  assign sda_oe = s.sda_oe;
  assign busy = s.busy;
  assign err = s.err;
  assign rbyte = s.rbyte;
endmodule : mcs_i2c

// >>> hw/mcs_regs.sv
// Module control and status registers of the read-out board.
// Assumes a host register port with single-cycle strobes and
// a timing receiver on an open-drain I2C pair.
//
// Operation
// - Boot bit drives loader mode pin, default one
// - Collection field, applied as soon as it is written
// - Geographic address strapped and used at power-up
// - Applied address moves timing/CAN, not collection
// - Status one shows per-device load success
// - Done bit follows loader done output
// - Error bit low on error, toggles on no card
// - Power-on-test bit high during loader reset
// - Link error bit while any counter nonzero
// - Timing ready bit mirrors receiver ready
// - Timing clock selected bit
// - Read-only version words with type and revision
// - CAN reset strobe, reads zero
// - CAN program bit, zero after reset
// - Four CAN interrupt strobes, read zero
// - Control change launches transfer unless busy, reset bit written or module reset on
// - Control holds data, direction, register number
// - Engine reset bit aborts transfer
// - Status holds read byte, busy, error
// - Base identifier register addresses receiver
// - Module reset strobe, reads zero
`timescale 1ns/10ps
module mcs_regs
  import mcs_pkg::*;
#(
  parameter logic [15:0] MODULE_TYPE = 16'h0a5c,  // Arbitrary value
  parameter logic [7:0]  LOGIC_TYPE = 8'h21,      // Arbitrary value
  parameter logic [7:0]  FPGA_TYPE = 8'h22,       // Arbitrary value
  parameter logic [7:0]  LOGIC_REV = 8'h01,
  parameter logic [7:0]  FPGA_REV = 8'h01,
  parameter int          QTR = I2C_QTR_CYC
) (
  input  logic        CLK,
  input  logic        RSTN,
  input  logic [3:0]  REG_ADDR,
  input  logic        REG_WR,
  input  logic        REG_RD,
  input  logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input  logic [7:0]  GEO_STRAP,
  input  logic        HOST_DEVICE_LOADED,
  input  logic [4:0]  INPUT_DEVICES_LOADED,
  input  logic        SWITCH_DEVICE_LOADED,
  input  logic        MONITOR_DEVICE_LOADED,
  input  logic        CFG_DONE,
  input  logic        CFG_NO_ERROR,
  input  logic        CFG_POR_TEST,
  input  logic [4:0]  LINK_ERR_NZ,
  input  logic        TIMING_READY,
  input  logic        TIMING_CLOCK_SELECTED,
  output logic        BOOT_MODE_PIN,
  output logic [2:0]  COLLECTION,
  output logic [7:0]  GEO_ADDR,
  output logic        MODULE_RESET,
  output logic        CAN_RESET,
  output logic        CAN_PROGRAM,
  output logic [3:0]  CAN_IRQ,
  input  logic        SCL_IN,
  output logic        SCL_OUT,
  output logic        SCL_OE,
  input  logic        SDA_IN,
  output logic        SDA_OUT,
  output logic        SDA_OE
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        boot_mode;
    logic [2:0]  coll;
    logic [7:0]  geo;
    logic [7:0]  geo_live;
    logic        strap_done;
    logic        can_prog;
    logic [15:0] i2c_ctl;
    logic [5:0]  i2c_id;
    logic        launch;
    logic [31:0] rdata;
  } mcs_regs_t;
  localparam mcs_regs_t REGS_RST = '{boot_mode: BOOT_RST, default: '0};
  localparam int NSTB = IRQ_W + 2;

  mcs_regs_t s, n;
  logic [NSTB-1:0] strobe;
  logic [NSTB-1:0] pulse;
  logic [31:0] rd_word;
  logic        i2c_busy;
  logic        i2c_err;
  logic [7:0]  i2c_rbyte;
  logic        eng_rst;

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always_comb begin
    n = s;
    n.launch = 1'b0;
    strobe = '0;
    rd_word = 32'h0000_0000;
    // Straps are caught by the clock after reset, never by the reset
    if (!s.strap_done) begin
      n.strap_done = 1'b1;
      n.geo = GEO_STRAP;
      n.geo_live = GEO_STRAP;
      n.coll = GEO_STRAP[COLL_W-1:0];
    end
    if (REG_WR) begin
      case (REG_ADDR)
        ADR_BOOT: begin
          n.boot_mode = REG_WDATA[BOOT_BIT];
          n.coll = REG_WDATA[COLL_LSB +: COLL_W];
          n.geo = REG_WDATA[GEO_LSB +: GEO_W];
        end
        ADR_CAN_CTL: begin
          n.can_prog = REG_WDATA[CAN_PROG_BIT];
          strobe[IRQ_W] = REG_WDATA[CAN_RST_BIT];
        end
        ADR_CAN_IRQ: strobe[IRQ_W-1:0] = REG_WDATA[IRQ_W-1:0];
        ADR_I2C_CTL: begin
          n.i2c_ctl = REG_WDATA[15:0] & I2C_CTL_MASK;
          // A write that lands while busy is kept but starts nothing
          if (n.i2c_ctl != s.i2c_ctl && !i2c_busy && !REG_WDATA[I2C_RST_BIT])
            n.launch = 1'b1;
        end
        ADR_I2C_ID: n.i2c_id = REG_WDATA[ID_W-1:0];
        ADR_MOD_RST: if (REG_WDATA[MOD_RST_BIT]) begin
          strobe[IRQ_W+1] = 1'b1;
          // Boot settings survive so the reload uses them
          n.geo_live = s.geo;
          n.can_prog = 1'b0;
          n.i2c_ctl = '0;
        end
        default: ;
      endcase
    end
    case (REG_ADDR)
      ADR_BOOT: rd_word = {20'h00000, s.geo, s.coll, s.boot_mode};
      ADR_STAT1: rd_word = {21'h000000, CFG_POR_TEST, CFG_NO_ERROR, CFG_DONE,
                            MONITOR_DEVICE_LOADED, SWITCH_DEVICE_LOADED,
                            INPUT_DEVICES_LOADED, HOST_DEVICE_LOADED};
      ADR_STAT2: rd_word = {29'h00000000, TIMING_CLOCK_SELECTED,
                            TIMING_READY, |LINK_ERR_NZ};
      ADR_VER_LOGIC: rd_word = {LOGIC_REV, LOGIC_TYPE, MODULE_TYPE};
      ADR_VER_FPGA: rd_word = {FPGA_REV, FPGA_TYPE, MODULE_TYPE};
      ADR_CAN_CTL: rd_word = {30'h00000000, s.can_prog, 1'b0};
      ADR_I2C_CTL: rd_word = {16'h0000, s.i2c_ctl};
      ADR_I2C_STAT: rd_word = {22'h000000, i2c_err, i2c_busy, i2c_rbyte};
      ADR_I2C_ID: rd_word = {26'h0000000, s.i2c_id};
      default: rd_word = 32'h0000_0000;  // Strobe words read zero
    endcase
    if (REG_RD) n.rdata = rd_word;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) s <= REGS_RST;
    else s <= n;
  end

  // ----------------------------------------
  // Strobes
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NSTB; gi++) begin : g_stb
      mcs_pulse #(.LEN(STROBE_CYC)) u_pulse (
        .clk   (CLK),
        .rstn  (RSTN),
        .trig  (strobe[gi]),
        .pulse (pulse[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Timing receiver access
  // ----------------------------------------
  // Engine reset is a level while the bit stays set
  assign eng_rst = s.i2c_ctl[I2C_RST_BIT] | MODULE_RESET;

  mcs_i2c #(.QTR(QTR)) u_i2c (
    .clk      (CLK),
    .rstn     (RSTN),
    .soft_rst (eng_rst),
    .launch   (s.launch),
    .dir      (s.i2c_ctl[I2C_DIR_BIT]),
    .regno    (s.i2c_ctl[I2C_REG_LSB +: I2C_REG_W]),
    .wbyte    (s.i2c_ctl[7:0]),
    .base_id  (s.i2c_id),
    .scl_in   (SCL_IN),
    .sda_in   (SDA_IN),
    .scl_oe   (SCL_OE),
    .sda_oe   (SDA_OE),
    .busy     (i2c_busy),
    .err      (i2c_err),
    .rbyte    (i2c_rbyte)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign REG_RDATA = s.rdata;
  assign BOOT_MODE_PIN = s.boot_mode;
  assign COLLECTION = s.coll;
  assign GEO_ADDR = s.geo_live;
  assign CAN_PROGRAM = s.can_prog;
  assign CAN_IRQ = pulse[IRQ_W-1:0];
  assign CAN_RESET = pulse[IRQ_W];
  assign MODULE_RESET = pulse[IRQ_W+1];
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  boot_pin_a: assert property (
    REG_WR && REG_ADDR == ADR_BOOT |=> BOOT_MODE_PIN == $past(REG_WDATA[BOOT_BIT]))
    else $error("boot mode pin not updated");

  boot_read_a: assert property (
    REG_RD && REG_ADDR == ADR_BOOT |=> REG_RDATA[3:0] == $past({COLLECTION, BOOT_MODE_PIN}))
    else $error("boot word readback wrong");

  coll_write_a: assert property (
    REG_WR && REG_ADDR == ADR_BOOT |=> COLLECTION == $past(REG_WDATA[COLL_LSB +: COLL_W]))
    else $error("collection not written");

  strap_take_a: assert property (
    !s.strap_done && !REG_WR
    |=> GEO_ADDR == $past(GEO_STRAP) && COLLECTION == $past(GEO_STRAP[COLL_W-1:0]))
    else $error("straps not captured");

  coll_hold_a: assert property (
    s.strap_done && !(REG_WR && REG_ADDR == ADR_BOOT) |=> $stable(COLLECTION))
    else $error("collection changed without boot write");

  geo_hold_a: assert property (
    s.strap_done && !(REG_WR && REG_ADDR == ADR_MOD_RST && REG_WDATA[MOD_RST_BIT]) |=> $stable(GEO_ADDR))
    else $error("applied address changed without module reset");

  geo_apply_a: assert property (
    REG_WR && REG_ADDR == ADR_MOD_RST && REG_WDATA[MOD_RST_BIT] && s.strap_done
    |=> GEO_ADDR == $past(s.geo))
    else $error("geographic address not applied");

  load_bits_a: assert property (
    REG_RD && REG_ADDR == ADR_STAT1 |=> REG_RDATA[7:0] == $past({MONITOR_DEVICE_LOADED,
      SWITCH_DEVICE_LOADED, INPUT_DEVICES_LOADED, HOST_DEVICE_LOADED}))
    else $error("load success bits wrong");

  loader_bits_a: assert property (
    REG_RD && REG_ADDR == ADR_STAT1 |=> REG_RDATA[10:8] == $past({CFG_POR_TEST, CFG_NO_ERROR, CFG_DONE})
      && REG_RDATA[31:11] == 21'h000000)
    else $error("loader status bits wrong");

  link_err_a: assert property (
    REG_RD && REG_ADDR == ADR_STAT2 |=> REG_RDATA[0] == $past(|LINK_ERR_NZ))
    else $error("link error bit wrong");

  clock_bits_a: assert property (
    REG_RD && REG_ADDR == ADR_STAT2 |=> REG_RDATA[2:1] == $past({TIMING_CLOCK_SELECTED, TIMING_READY}))
    else $error("timing clock bits wrong");

  version_a: assert property (
    REG_RD && REG_ADDR == ADR_VER_LOGIC |=> REG_RDATA[31:24] == LOGIC_REV)
    else $error("version revision wrong");

  fpga_version_a: assert property (
    REG_RD && REG_ADDR == ADR_VER_FPGA |=> REG_RDATA[31:24] == FPGA_REV && REG_RDATA[15:0] == MODULE_TYPE)
    else $error("second version word wrong");

  can_reset_a: assert property (
    REG_WR && REG_ADDR == ADR_CAN_CTL && REG_WDATA[CAN_RST_BIT] |=> CAN_RESET [*8])
    else $error("CAN reset strobe too short");

  can_rise_a: assert property (
    $rose(CAN_RESET) |-> $past(REG_WR && REG_ADDR == ADR_CAN_CTL && REG_WDATA[CAN_RST_BIT]))
    else $error("CAN reset without request");

  can_read_a: assert property (
    REG_RD && REG_ADDR == ADR_CAN_CTL |=> REG_RDATA[CAN_RST_BIT] == 1'b0
      && REG_RDATA[CAN_PROG_BIT] == $past(CAN_PROGRAM))
    else $error("CAN control readback wrong");

  can_prog_a: assert property (
    REG_WR && REG_ADDR == ADR_CAN_CTL |=> CAN_PROGRAM == $past(REG_WDATA[CAN_PROG_BIT]))
    else $error("CAN program bit not written");

  irq_strobe_a: assert property (
    REG_WR && REG_ADDR == ADR_CAN_IRQ && REG_WDATA[2] |=> CAN_IRQ[2] ##1 CAN_IRQ[2])
    else $error("CAN interrupt strobe missing");

  irq_rise_a: assert property (
    $rose(CAN_IRQ[0]) |-> $past(REG_WR && REG_ADDR == ADR_CAN_IRQ && REG_WDATA[0]))
    else $error("CAN interrupt without request");

  strobe_read_a: assert property (
    REG_RD && (REG_ADDR == ADR_CAN_IRQ || REG_ADDR == ADR_MOD_RST) |=> REG_RDATA == 32'h0000_0000)
    else $error("strobe word reads nonzero");

  i2c_launch_a: assert property (
    REG_WR && REG_ADDR == ADR_I2C_CTL && !i2c_busy && !REG_WDATA[I2C_RST_BIT] && !eng_rst
      && (REG_WDATA[15:0] & I2C_CTL_MASK) != s.i2c_ctl |=> ##1 i2c_busy && !i2c_err)
    else $error("transfer not launched");

  ctl_read_a: assert property (
    REG_RD && REG_ADDR == ADR_I2C_CTL |=> REG_RDATA[31:16] == 16'h0000 && !REG_RDATA[14])
    else $error("control word unused bits set");

  eng_abort_a: assert property (
    s.i2c_ctl[I2C_RST_BIT] |=> !i2c_busy && !SCL_OE && !SDA_OE)
    else $error("engine reset did not abort");

  i2c_stat_a: assert property (
    REG_RD && REG_ADDR == ADR_I2C_STAT
    |=> REG_RDATA[9:8] == $past({i2c_err, i2c_busy}) && REG_RDATA[7:0] == $past(i2c_rbyte))
    else $error("transfer status readback wrong");

  idle_free_a: assert property (
    !i2c_busy |-> !SCL_OE && !SDA_OE)
    else $error("bus lines held while idle");

  mod_rst_a: assert property (
    REG_WR && REG_ADDR == ADR_MOD_RST && REG_WDATA[MOD_RST_BIT]
    |=> MODULE_RESET && !CAN_PROGRAM ##1 !i2c_busy)
    else $error("module reset incomplete");

  busy_store_a: assert property (
    REG_WR && REG_ADDR == ADR_I2C_CTL && i2c_busy
    |=> !s.launch && s.i2c_ctl == ($past(REG_WDATA[15:0]) & I2C_CTL_MASK))
    else $error("busy write mishandled");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  xfer_cov: cover property ($rose(i2c_busy) ##[1:1000] $fell(i2c_busy));
  abort_cov: cover property (i2c_busy && eng_rst);
  modrst_cov: cover property ($rose(MODULE_RESET));
  irq_cov: cover property (CAN_IRQ == 4'hf);
  nack_cov: cover property ($rose(i2c_err));
endmodule : mcs_regs

// >>> bench/mcs_rx_model.sv
// Behavioural timing receiver on an open-drain I2C pair.
// Assumes pulled-up lines; sda_oe high pulls the data line low.
`timescale 1ns/10ps
module mcs_rx_model #(
  parameter logic [5:0] ID = 6'h15
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  // ----------------------------------------
  // Byte framing, ack and read data
  // ----------------------------------------
  logic [7:0] mem [32];
  logic [7:0] sh;
  logic [4:0] rg;
  logic       rd;
  logic       ok;
  int         cnt;
  int         nb;
  initial begin
    sda_oe = 1'b0;
    cnt = 0;
    nb = 0;
    ok = 1'b0;
    rd = 1'b0;
    for (int i = 0; i < 32; i++) mem[i] = 8'h40 + 8'(i);
  end
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      nb = 0;
    end
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Released line reads high through the pull-up, never the last driven bit
  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (cnt == 9) begin
      cnt = 0;
      nb = nb + 1;
    end
    if (cnt == 8) begin
      if (nb == 0) begin
        ok = (sh[7:1] == {ID, 1'b0});
        rd = sh[0];
      end
      if (nb == 1) begin
        rg = sh[4:0];
        ok = ok && (sh[7:5] == 3'h0);
      end
      if (nb == 2 && !rd && ok) mem[rg] = sh;
      sda_oe = ok && !(nb == 2 && rd);
    end else if (nb == 2 && rd && ok) begin
      sda_oe = !mem[rg][7 - cnt];
    end
  end
endmodule : mcs_rx_model

// >>> bench/test_module_control_status_regs.sv
// Self-checking bench for the module control and status registers.
// Assumes a pulled-up I2C pair joined to a behavioural receiver.
`timescale 1ns/10ps
module test_module_control_status_regs
  import mcs_pkg::*;
;
  // ----------------------------------------
  // Stimulus, checks and scenarios
  // ----------------------------------------
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_WDATA = 32'h0;
  logic [31:0] REG_RDATA;
  logic [4:0]  inp = 5'h0;
  logic [4:0]  lnk = 5'h0;
  logic [2:0]  coll;
  logic [7:0]  geo;
  logic [3:0]  irq;
  logic [7:0]  m = 8'h0;
  logic        bmp, mrst, crst, cprog, scl_oe, sda_oe, m_oe, scl, sda;
  logic [31:0] v;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          n_mr, n_cr;
  int          n_irq [4];
  always #2.5 CLK = !CLK;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || m_oe);
  mcs_regs #(.QTR(4)) dut_u (
    .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .GEO_STRAP(8'h5a), .HOST_DEVICE_LOADED(m[0]),
    .INPUT_DEVICES_LOADED(inp), .SWITCH_DEVICE_LOADED(m[1]), .MONITOR_DEVICE_LOADED(m[2]),
    .CFG_DONE(m[3]), .CFG_NO_ERROR(m[4]), .CFG_POR_TEST(m[5]), .LINK_ERR_NZ(lnk),
    .TIMING_READY(m[6]), .TIMING_CLOCK_SELECTED(m[7]), .BOOT_MODE_PIN(bmp), .COLLECTION(coll),
    .GEO_ADDR(geo), .MODULE_RESET(mrst), .CAN_RESET(crst), .CAN_PROGRAM(cprog), .CAN_IRQ(irq),
    .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe));
  mcs_rx_model #(.ID(6'h15)) mdl_u (.scl(scl), .sda(sda), .sda_oe(m_oe));
  always @(negedge CLK) begin
    n_mr += mrst;
    n_cr += crst;
    for (int i = 0; i < 4; i++) n_irq[i] += irq[i];
  end
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge CLK);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
  endtask : rd
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(ADR_I2C_STAT, v);
      n++;
    end while (v[8] !== 1'b0 && n < 2000);
    chk(32'(n < 2000), 32'h1);
  endtask : idle
  task automatic t_reset;
    chk({bmp, coll, geo}, {1'b1, 3'h2, 8'h5a});
    rd(ADR_BOOT, v);
    chk(v, 32'h5a5);
    rd(ADR_VER_LOGIC, v);
    chk(v, 32'h01210a5c);
    rd(ADR_VER_FPGA, v);
    chk(v, 32'h01220a5c);
    wr(ADR_VER_FPGA, 32'h0);
    rd(ADR_VER_FPGA, v);
    chk(v, 32'h01220a5c);
    rd(ADR_I2C_CTL, v);
    chk({v, 32'(cprog)}, 64'h0);
    rd(ADR_I2C_STAT, v);
    chk(v, 32'h0);
    rd(4'hf, v);
    chk(v, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_status;
    for (int i = 0; i < 6; i++) begin
      inp = 5'(1 << i);
      lnk = inp;
      m = 8'(i * 8'h2b);
      rd(ADR_STAT1, v);
      chk(v, {21'h0, m[5:3], m[2:1], inp, m[0]});
      rd(ADR_STAT2, v);
      chk(v, {29'h0, m[7:6], |lnk});
    end
    $display("test status done");
  endtask : t_status
  task automatic t_can;
    n_cr = 0;
    wr(ADR_CAN_CTL, 32'h3);
    repeat (50) @(negedge CLK);
    chk({32'(cprog), 32'(n_cr)}, {32'h1, 32'd40});
    rd(ADR_CAN_CTL, v);
    chk(v, 32'h2);
    wr(ADR_CAN_CTL, 32'h1);
    wr(ADR_CAN_CTL, 32'h0);
    repeat (50) @(negedge CLK);
    chk({32'(cprog), 32'(n_cr)}, {32'h0, 32'd80});
    for (int i = 0; i < 5; i++) begin
      n_irq = '{0, 0, 0, 0};
      wr(ADR_CAN_IRQ, 32'(1 << i));
      repeat (50) @(negedge CLK);
      for (int k = 0; k < 4; k++) chk(n_irq[k], (k == i) ? 40 : 0);
    end
    rd(ADR_CAN_IRQ, v);
    chk(v, 32'h0);
    $display("test can done");
  endtask : t_can
  task automatic t_i2c;
    wr(ADR_I2C_ID, 32'h15);
    wr(ADR_I2C_CTL, 32'h19a7);
    repeat (2) @(negedge CLK);
    rd(ADR_I2C_STAT, v);
    chk(v[9:8], 2'b01);
    wr(ADR_I2C_CTL, 32'h1b55);
    idle();
    repeat (100) @(negedge CLK);
    rd(ADR_I2C_STAT, v);
    chk(v[9:8], 2'b00);
    chk({mdl_u.mem[12], mdl_u.mem[13]}, 16'ha74d);
    rd(ADR_I2C_CTL, v);
    chk(v, 32'h1b55);
    wr(ADR_I2C_CTL, 32'h1800);
    idle();
    chk(v[9:0], 10'h0a7);
    $display("test i2c done");
  endtask : t_i2c
  task automatic t_err;
    wr(ADR_I2C_ID, 32'h14);
    wr(ADR_I2C_CTL, 32'h0100);
    idle();
    chk(v[9:8], 2'b10);
    wr(ADR_I2C_ID, 32'h15);
    wr(ADR_I2C_CTL, 32'h0000);
    repeat (2) @(negedge CLK);
    rd(ADR_I2C_STAT, v);
    chk(v[9:8], 2'b01);
    idle();
    chk(v[9:0], 10'h040);
    wr(ADR_I2C_CTL, 32'h0300);
    repeat (60) @(negedge CLK);
    wr(ADR_I2C_CTL, 32'h8300);
    @(negedge CLK);
    chk({scl_oe, sda_oe}, 2'b00);
    rd(ADR_I2C_STAT, v);
    chk(v[8], 1'b0);
    wr(ADR_I2C_CTL, 32'h0300);
    idle();
    chk({v[9:0], mdl_u.mem[1]}, 18'h00000);
    $display("test error and abort done");
  endtask : t_err
  task automatic t_boot;
    wr(ADR_CAN_CTL, 32'h2);
    wr(ADR_BOOT, 32'h33a);
    chk(bmp, 1'b0);
    n_mr = 0;
    wr(ADR_MOD_RST, 32'h0);
    wr(ADR_MOD_RST, 32'h1);
    repeat (50) @(negedge CLK);
    chk({n_mr, 24'(coll), geo, 31'h0, cprog}, {32'd40, 24'h5, 8'h33, 32'h0});
    rd(ADR_MOD_RST, v);
    chk(v, 32'h0);
    rd(ADR_BOOT, v);
    chk(v, 32'h33a);
    $display("test boot and module reset done");
  endtask : t_boot
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  // Watchdog: all frames at a quarter of 4 cycles fit well inside this span
  initial begin
    #400us;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge CLK);
    RSTN = 1'b1;
    repeat (3) @(negedge CLK);
    t_reset();
    t_status();
    t_can();
    t_i2c();
    t_err();
    t_boot();
    finish_test();
  end
endmodule : test_module_control_status_regs
